// [bench/test_wsfu_unpacker.sv]
// Self-checking bench for the frame unpacker with source/decoder model.
// Assumes wsfu_pkg, wsfu_unpacker, the checker and the partner compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("CHECK FAILED %0t field mismatch", $time); end end
module test_wsfu_unpacker;
import wsfu_pkg::*;
logic clk = 1'b0, reset = 1'b1, ce = 1'b1, go = 1'b0, mode = 1'b0, saw_full = 1'b0;
logic bit_valid, bit_ready, bit_data, bit_mode_full, sf_valid, sf_ready, sf_last;
logic frame_mode_full, frame_len_ok, voice_activity_detector, sf_pitch_relative, filt, hbv;
logic [1:0] sf_index;
logic [SPV_BUS_W-1:0] spv;
logic [W_PITCH_ABS-1:0] sf_pitch;
logic [N_PULSE*W_PULSE-1:0] sf_pulse;
logic [W_GAIN-1:0] sf_gain;
logic [W_HBE-1:0] sf_hb_gain;
logic [1:477] exp;
int nbits = 0, stall = 0, sent, bad_count = 0, n_checks = 0;
always #25 clk = ~clk;
always @(negedge clk) if (bit_ready === 1'b0 && ce) saw_full <= 1'b1;
wsfu_unpacker i_wsfu_unpacker (.CLK(clk), .RESET(reset), .CE(ce), .BIT_VALID(bit_valid),
	.BIT_READY(bit_ready), .BIT_DATA(bit_data), .BIT_MODE_FULL(bit_mode_full),
	.SF_VALID(sf_valid), .SF_READY(sf_ready), .SF_INDEX(sf_index), .SF_LAST(sf_last),
	.FRAME_MODE_FULL(frame_mode_full), .FRAME_LEN_OK(frame_len_ok),
	.VOICE_ACTIVITY_FLAG(voice_activity_detector), .SPECTRAL_PAIR_SUBVECTOR(spv), .SF_PITCH(sf_pitch),
	.SF_PITCH_RELATIVE(sf_pitch_relative), .PITCH_FILTER_SELECT_FLAG(filt),
	.SF_PULSE(sf_pulse), .SF_GAIN(sf_gain), .SF_HB_GAIN(sf_hb_gain), .SF_HB_GAIN_VALID(hbv));
wsfu_partner i_wsfu_partner (.CLK(clk), .RESET(reset), .frame(exp), .nbits(nbits),
	.mode(mode), .go(go), .stall(stall), .BIT_READY(bit_ready), .SF_VALID(sf_valid),
	.BIT_VALID(bit_valid), .BIT_DATA(bit_data), .BIT_MODE_FULL(bit_mode_full),
	.SF_READY(sf_ready), .sent(sent));
////////////////////////////////////////////////////////////////////////////////
function automatic logic [10:0] fld(int a, int w);
	logic [10:0] v;
	v = '0;
	for (int i = 0; i < w; i++)
		v = {v[9:0], exp[a+i]};
	return v;
endfunction
task conclude;
	$display("checks %0d mismatches %0d", n_checks, bad_count);
	if (bad_count == 0 && n_checks > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
// Checks one subframe at the cycle before its taking edge
task check_sf(int k);
	int p, pw;
	p = mode ? (k == 0 ? 48 : k == 1 ? 157 : k == 2 ? 263 : 372)
		: (k == 0 ? 48 : k == 1 ? 153 : k == 2 ? 255 : 360);
	pw = k[0] ? 6 : 9;
	`CHK(sf_index, k[1:0])
	`CHK(voice_activity_detector, exp[1])
	`CHK(spv, exp[2:47])
	`CHK({2'h0, sf_pitch}, fld(p, pw))
	`CHK(filt, exp[p+pw])
	for (int j = 0; j < 8; j++)
		`CHK(sf_pulse[j*11+:11], fld(p + pw + 1 + 11 * j, 11))
	`CHK({4'h0, sf_gain}, fld(p + pw + 89, 7))
	`CHK({7'h0, sf_hb_gain}, mode ? fld(p + pw + 96, 4) : 11'h000)
	`CHK(frame_mode_full, mode)
	`CHK(sf_last, k == 3)
	`CHK(frame_len_ok, k == 3)
	`CHK(hbv, mode)
endtask
task run_frame(logic full, int kind, int st);
	int t;
	for (int i = 1; i <= 477; i++)
		exp[i] = (kind == 0) ? 1'b1 : 1'(((i * kind) + (i >> 2)) % 3 == 0);
	{mode, stall, nbits} = {full, st, full ? 477 : 461};
	go = 1'b1;
	@(posedge clk);
	#1 go = 1'b0;
	for (int k = 0; k < 4; k++)
	begin
		// Mid-cycle look: the model raises ready in the same step as the bench
		for (t = 0; t < 4000 && !(sf_valid === 1'b1 && sf_ready === 1'b1); t++)
			@(negedge clk);
		if (t == 4000)
		begin
			bad_count++;
			$display("CHECK FAILED %0t subframe wait ran out", $time);
			conclude();
		end
		check_sf(k);
		@(posedge clk);
		#1;
	end
	`CHK(sent, nbits)
endtask
task t_full;
	run_frame(1'b1, 1, 0);
	run_frame(1'b1, 0, 0);
endtask
task t_short;
	run_frame(1'b0, 2, 0);
	run_frame(1'b0, 0, 3);
endtask
// Slow decoder fills the 16-deep FIFO so input is refused
task t_stall;
	saw_full = 1'b0;
	run_frame(1'b1, 3, 40);
	`CHK(saw_full, 1'b1)
endtask
task t_reset;
	fork
		run_frame(1'b1, 1, 0);
	join_none
	repeat (100) @(posedge clk);
	#1 ce = 1'b0;
	repeat (3) @(posedge clk);
	#1 `CHK(bit_ready, 1'b0)
	ce = 1'b1;
	reset = 1'b1;
	disable fork;
	repeat (2) @(posedge clk);
	#1 `CHK({sf_valid, sf_index, voice_activity_detector, spv}, '0)
	`CHK(bit_ready, 1'b1)
	reset = 1'b0;
	run_frame(1'b0, 4, 1);
endtask
initial
begin
	repeat (4) @(posedge clk);
	#1 reset = 1'b0;
	t_full();
	t_short();
	t_stall();
	t_reset();
	conclude();
end
endmodule
`undef CHK
`default_nettype wire

// [bench/wsfu_checker.sv]
// Port-level assertions for the frame unpacker.
// Assumes binding onto wsfu_unpacker; one clock, asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module wsfu_checker
	import wsfu_pkg::*;
(
	input wire logic                   CLK,
	input wire logic                   RESET,
	input wire logic                   CE,
	input wire logic                   SF_VALID,
	input wire logic                   SF_READY,
	input wire logic [1:0]             SF_INDEX,
	input wire logic                   SF_LAST,
	input wire logic                   FRAME_MODE_FULL,
	input wire logic                   FRAME_LEN_OK,
	input wire logic [SPV_BUS_W-1:0]   SPECTRAL_PAIR_SUBVECTOR,
	input wire logic [W_PITCH_ABS-1:0] SF_PITCH,
	input wire logic                   SF_PITCH_RELATIVE,
	input wire logic [W_GAIN-1:0]      SF_GAIN,
	input wire logic [W_HBE-1:0]       SF_HB_GAIN,
	input wire logic                   SF_HB_GAIN_VALID
);
default clocking cb @(posedge CLK); endclocking
default disable iff (RESET);
////////////////////////////////////////////////////////////////////////////////
last_flag_a: assert property (SF_LAST == (SF_INDEX == 2'h3))
	else $error("last flag does not follow subframe index");
hb_valid_a: assert property (SF_HB_GAIN_VALID == FRAME_MODE_FULL)
	else $error("energy valid differs from frame mode");
hb_zero_a: assert property (!FRAME_MODE_FULL |-> SF_HB_GAIN == 4'h0)
	else $error("energy index nonzero in short mode");
pitch_kind_a: assert property (SF_VALID |-> SF_PITCH_RELATIVE == SF_INDEX[0])
	else $error("pitch kind wrong for subframe");
rel_width_a: assert property (SF_VALID && SF_PITCH_RELATIVE |-> SF_PITCH[8:6] == 3'h0)
	else $error("relative pitch wider than six bits");
hold_out_a: assert property (SF_VALID && !(SF_READY && CE) |=> SF_VALID && $stable(SF_PITCH) && $stable(SF_INDEX) && $stable(SF_GAIN))
	else $error("subframe output changed before taken");
sf_order_a: assert property (SF_VALID && SF_READY && CE |=> !SF_VALID && SF_INDEX == $past(SF_INDEX) + 2'h1)
	else $error("subframe order broken");
len_ok_a: assert property (SF_VALID && SF_LAST |-> FRAME_LEN_OK)
	else $error("frame bit count wrong at last subframe");
frame_hold_a: assert property ($rose(SF_VALID) && SF_INDEX != 2'h0 |-> $stable(SPECTRAL_PAIR_SUBVECTOR))
	else $error("frame fields moved within frame");
endmodule
bind wsfu_unpacker wsfu_checker i_wsfu_checker (.CLK(CLK), .RESET(RESET), .CE(CE),
	.SF_VALID(SF_VALID), .SF_READY(SF_READY), .SF_INDEX(SF_INDEX), .SF_LAST(SF_LAST),
	.FRAME_MODE_FULL(FRAME_MODE_FULL), .FRAME_LEN_OK(FRAME_LEN_OK),
	.SPECTRAL_PAIR_SUBVECTOR(SPECTRAL_PAIR_SUBVECTOR), .SF_PITCH(SF_PITCH),
	.SF_PITCH_RELATIVE(SF_PITCH_RELATIVE), .SF_GAIN(SF_GAIN), .SF_HB_GAIN(SF_HB_GAIN),
	.SF_HB_GAIN_VALID(SF_HB_GAIN_VALID));
`default_nettype wire

// [bench/wsfu_partner.sv]
// Frame source and speech decoder model facing the unpacker.
// Assumes go pulses one cycle to start a frame of nbits bits.
`timescale 1ns/1ps
`default_nettype none
module wsfu_partner
(
	input wire logic         CLK,
	input wire logic         RESET,
	input wire logic [1:477] frame,
	input wire integer       nbits,
	input wire logic         mode,
	input wire logic         go,
	input wire integer       stall,
	input wire logic         BIT_READY,
	input wire logic         SF_VALID,
	output logic             BIT_VALID,
	output logic             BIT_DATA,
	output logic             BIT_MODE_FULL,
	output logic             SF_READY,
	output int               sent
);
logic take, took, g, r;
int   wcnt;
initial {BIT_VALID, BIT_DATA, BIT_MODE_FULL, SF_READY, sent, wcnt} = '0;
always
begin
	@(posedge CLK);
	{take, took, g, r} = {BIT_VALID & BIT_READY, SF_VALID & SF_READY, go, RESET};
	#1;
	if (take)
		sent = sent + 1;
	if (g)
		sent = 0;
	if (r)
		sent = nbits;
	BIT_VALID = (sent < nbits);
	// Data held until taken; idle line toggles so no stale bit looks valid
	if (!BIT_VALID)
		BIT_DATA = ~BIT_DATA;
	else if (take || g)
		BIT_DATA = frame[sent+1];
	BIT_MODE_FULL = (BIT_VALID && sent == 0) ? mode : ~mode;
	if (took || r)
	begin
		SF_READY = 1'b0;
		wcnt = 0;
	end
	else if (SF_VALID)
	begin
		if (wcnt >= stall)
			SF_READY = 1'b1;
		wcnt = wcnt + 1;
	end
end
endmodule
`default_nettype wire

// [hdl/wsfu_pkg.sv]
// Constants and types for the wideband speech frame unpacker.
// Assumes a single clock domain; shared by the unpacker and its bit FIFO.
package wsfu_pkg;

	localparam int unsigned FRAME_BITS_FULL = 477;	// Mode with high-band energy
	localparam int unsigned FRAME_BITS_NOHB = 461;	// Mode without high-band energy
	localparam int unsigned FRAME_CNT_W     = 9;

	localparam int unsigned N_SPV      = 7;
	localparam int unsigned SPV_MAX_W  = 8;
	localparam int unsigned SPV_W0     = 8;
	localparam int unsigned SPV_W1     = 8;
	localparam int unsigned SPV_W2     = 6;
	localparam int unsigned SPV_W3     = 7;
	localparam int unsigned SPV_W4     = 7;
	localparam int unsigned SPV_W5     = 5;
	localparam int unsigned SPV_W6     = 5;
	localparam int unsigned SPV_BUS_W  = 46;

	localparam int unsigned W_VAD       = 1;
	localparam int unsigned W_PITCH_ABS = 9;
	localparam int unsigned W_PITCH_REL = 6;
	localparam int unsigned W_FILT      = 1;
	localparam int unsigned W_PULSE     = 11;
	localparam int unsigned N_PULSE     = 8;
	localparam int unsigned W_GAIN      = 7;
	localparam int unsigned W_HBE       = 4;
	localparam int unsigned ACC_W       = 11;
	localparam int unsigned FLD_CNT_W   = 4;

	localparam int unsigned N_SUBFR     = 4;
	localparam logic [1:0]  SUBFR_LAST  = 2'h3;
	localparam logic [1:0]  SUBFR_ABS2  = 2'h2;

	localparam int unsigned FIFO_WIDTH  = 2;
	localparam int unsigned FIFO_DEPTH  = 16;

	typedef enum logic [3:0] {
		ST_VAD,
		ST_SPV,
		ST_PITCH_ABS,
		ST_PITCH_REL,
		ST_FILT,
		ST_PULSE,
		ST_GAIN,
		ST_HBE,
		ST_OUT
	} wsfu_state_t;

endpackage

// [hdl/wsfu_unpacker.sv]
// Serial frame unpacker for the two highest-rate wideband speech modes,
// with the input bit FIFO that buffers the serial stream.
// Assumes source and decoder sit on CLK; all inputs are synchronous to it.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Bit FIFO: valid/ready on both sides, honest full and empty
module wsfu_fifo
	import wsfu_pkg::*;
#(
	parameter int unsigned WIDTH = FIFO_WIDTH,
	parameter int unsigned DEPTH = FIFO_DEPTH
)(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0]      wr_ptr_ff;
	logic [AW:0]      rd_ptr_ff;
	wire              full;
	wire              empty;
	wire              push;
	wire              pop;

	assign full      = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
	assign empty     = (wr_ptr_ff == rd_ptr_ff);
	assign in_ready  = ce & ~full;
	assign out_valid = ~empty;
	assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];
	assign push      = in_valid & in_ready;
	assign pop       = ce & out_ready & ~empty;

	always_ff @(posedge clk)
	begin
		if (push)
			mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Function
// - Full-mode frame holds 477 bits; all are consumed before completion.
// - Every field arrives MSB first and is shifted in MSB to LSB.
// - Bit 1 is voice activity; bits 2-9 first 8-bit subvector index.
// - Bits 10-17 second index (8 bits); bits 18-23 third index (6 bits).
// - Bits 24-30 fourth index, bits 31-37 fifth index, 7 bits each.
// - Bits 38-42 sixth and 43-47 seventh index, 5 bits each.
// - Subframe one: 9-bit absolute pitch, filter flag, then first pulse index.
// - First pulse indices of tracks two to four follow, 11 bits each.
// - Second pulse indices of tracks one to four follow, 11 bits each.
// - 7-bit gain index, then 4-bit high-band energy in full mode only.
// - Full mode subframe two starts with a 6-bit relative pitch index.
// - Full mode subframe two then repeats filter flag through high-band energy.
// - Full mode subframe three repeats subframe one with absolute pitch.
// - Full mode subframe four repeats subframe two with relative pitch.
// - 461-bit mode: no energy field; relative pitch at bits 153-158.
// - 461-bit mode subframe three repeats subframe one layout.
// - 461-bit mode subframe four repeats subframe two, ending at bit 461.
// - Second mode carries exactly 461 bits per frame.
module wsfu_unpacker
	import wsfu_pkg::*;
#(
	parameter int unsigned DEPTH = FIFO_DEPTH
)(
	input  wire logic                   CLK,
	input  wire logic                   RESET,
	input  wire logic                   CE,
	input  wire logic                   BIT_VALID,
	output logic                        BIT_READY,
	input  wire logic                   BIT_DATA,
	input  wire logic                   BIT_MODE_FULL,
	output logic                        SF_VALID,
	input  wire logic                   SF_READY,
	output logic [1:0]                  SF_INDEX,
	output logic                        SF_LAST,
	output logic                        FRAME_MODE_FULL,
	output logic                        FRAME_LEN_OK,
	output logic                        VOICE_ACTIVITY_FLAG,
	output logic [SPV_BUS_W-1:0]        SPECTRAL_PAIR_SUBVECTOR,
	output logic [W_PITCH_ABS-1:0]      SF_PITCH,
	output logic                        SF_PITCH_RELATIVE,
	output logic                        PITCH_FILTER_SELECT_FLAG,
	output logic [N_PULSE*W_PULSE-1:0]  SF_PULSE,
	output logic [W_GAIN-1:0]           SF_GAIN,
	output logic [W_HBE-1:0]            SF_HB_GAIN,
	output logic                        SF_HB_GAIN_VALID
);

	function automatic logic [FLD_CNT_W-1:0] spv_width(input logic [2:0] idx);
		case (idx)
			3'h0:    spv_width = FLD_CNT_W'(SPV_W0);
			3'h1:    spv_width = FLD_CNT_W'(SPV_W1);
			3'h2:    spv_width = FLD_CNT_W'(SPV_W2);
			3'h3:    spv_width = FLD_CNT_W'(SPV_W3);
			3'h4:    spv_width = FLD_CNT_W'(SPV_W4);
			3'h5:    spv_width = FLD_CNT_W'(SPV_W5);
			default: spv_width = FLD_CNT_W'(SPV_W6);
		endcase
	endfunction

	function automatic logic [FLD_CNT_W-1:0] field_width(input wsfu_state_t st,
		input logic [2:0] idx);
		case (st)
			ST_SPV:       field_width = spv_width(idx);
			ST_PITCH_ABS: field_width = FLD_CNT_W'(W_PITCH_ABS);
			ST_PITCH_REL: field_width = FLD_CNT_W'(W_PITCH_REL);
			ST_PULSE:     field_width = FLD_CNT_W'(W_PULSE);
			ST_GAIN:      field_width = FLD_CNT_W'(W_GAIN);
			ST_HBE:       field_width = FLD_CNT_W'(W_HBE);
			ST_FILT:      field_width = FLD_CNT_W'(W_FILT);
			default:      field_width = FLD_CNT_W'(W_VAD);
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Input buffering; back-pressure reaches the source through BIT_READY
	wire                  fifo_valid;
	wire                  fifo_ready;
	wire [FIFO_WIDTH-1:0] fifo_data;

	wsfu_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (DEPTH)
	) i_wsfu_fifo (
		.clk       (CLK),
		.reset     (RESET),
		.ce        (CE),
		.in_valid  (BIT_VALID),
		.in_ready  (BIT_READY),
		.in_data   ({BIT_MODE_FULL, BIT_DATA}),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Parser state
	wsfu_state_t              state_ff;
	wsfu_state_t              nxt_state;
	logic [FLD_CNT_W-1:0]     bit_cnt_ff;
	logic [ACC_W-1:0]         acc_ff;
	logic [2:0]               spv_cnt_ff;
	logic [2:0]               pulse_cnt_ff;
	logic [1:0]               sf_ff;
	logic                     mode_ff;
	logic [FRAME_CNT_W-1:0]   frame_bits_ff;
	logic                     vad_ff;
	logic [SPV_MAX_W-1:0]     spv_ff [N_SPV];
	logic [W_PITCH_ABS-1:0]   pitch_ff;
	logic                     pitch_rel_ff;
	logic                     filt_ff;
	logic [W_PULSE-1:0]       pulse_ff [N_PULSE];
	logic [W_GAIN-1:0]        gain_ff;
	logic [W_HBE-1:0]         hbe_ff;

	wire                      in_bit;
	wire                      take;
	wire                      field_end;
	wire [ACC_W-1:0]          nxt_acc;
	wire [FLD_CNT_W-1:0]      fld_w;
	wire                      out_take;
	wire                      cur_mode;
	wire [FRAME_CNT_W-1:0]    exp_bits;

	assign in_bit     = fifo_data[0];
	// Parsing stalls while a finished subframe waits for the decoder
	assign fifo_ready = CE & (state_ff != ST_OUT);
	assign take       = fifo_valid & fifo_ready;
	assign fld_w      = field_width(state_ff, spv_cnt_ff);
	assign field_end  = take & (bit_cnt_ff == fld_w - 1'b1);
	assign nxt_acc    = {acc_ff[ACC_W-2:0], in_bit};
	assign out_take   = CE & (state_ff == ST_OUT) & SF_READY;
	// Mode is caught at the frame's first bit and held for the frame
	assign cur_mode   = (state_ff == ST_VAD) ? fifo_data[1] : mode_ff;
	assign exp_bits   = mode_ff ? FRAME_CNT_W'(FRAME_BITS_FULL)
		: FRAME_CNT_W'(FRAME_BITS_NOHB);

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_VAD:       nxt_state = ST_SPV;
			ST_SPV:       nxt_state = (spv_cnt_ff == 3'(N_SPV - 1)) ? ST_PITCH_ABS : ST_SPV;
			ST_PITCH_ABS: nxt_state = ST_FILT;
			ST_PITCH_REL: nxt_state = ST_FILT;
			ST_FILT:      nxt_state = ST_PULSE;
			ST_PULSE:     nxt_state = (pulse_cnt_ff == 3'(N_PULSE - 1)) ? ST_GAIN : ST_PULSE;
			ST_GAIN:      nxt_state = cur_mode ? ST_HBE : ST_OUT;
			ST_HBE:       nxt_state = ST_OUT;
			default:      nxt_state = ST_VAD;
		endcase
	end

	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			state_ff      <= ST_VAD;
			bit_cnt_ff    <= '0;
			acc_ff        <= '0;
			spv_cnt_ff    <= '0;
			pulse_cnt_ff  <= '0;
			sf_ff         <= '0;
			mode_ff       <= 1'b0;
			frame_bits_ff <= '0;
		end
		else if (out_take)
		begin
			// Subframes 2 and 4 relative, 3 absolute
			sf_ff    <= sf_ff + 1'b1;
			state_ff <= (sf_ff == SUBFR_LAST) ? ST_VAD
				: ((sf_ff + 1'b1) == SUBFR_ABS2) ? ST_PITCH_ABS : ST_PITCH_REL;
		end
		else if (take)
		begin
			acc_ff        <= field_end ? '0 : nxt_acc;
			bit_cnt_ff    <= field_end ? '0 : bit_cnt_ff + 1'b1;
			frame_bits_ff <= (state_ff == ST_VAD) ? FRAME_CNT_W'(1)
				: frame_bits_ff + 1'b1;
			if (state_ff == ST_VAD)
				mode_ff <= fifo_data[1];
			if (field_end)
			begin
				state_ff <= nxt_state;
				if (state_ff == ST_SPV)
					spv_cnt_ff <= (nxt_state == ST_SPV) ? spv_cnt_ff + 1'b1 : '0;
				if (state_ff == ST_PULSE)
					pulse_cnt_ff <= (nxt_state == ST_PULSE) ? pulse_cnt_ff + 1'b1 : '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Field capture; held stable while SF_VALID stands
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			vad_ff       <= 1'b0;
			spv_ff       <= '{default: '0};
			pitch_ff     <= '0;
			pitch_rel_ff <= 1'b0;
			filt_ff      <= 1'b0;
			pulse_ff     <= '{default: '0};
			gain_ff      <= '0;
			hbe_ff       <= '0;
		end
		else if (field_end)
		begin
			case (state_ff)
				ST_VAD:       vad_ff <= in_bit;
				ST_SPV:       spv_ff[spv_cnt_ff] <= nxt_acc[SPV_MAX_W-1:0];
				ST_PITCH_ABS:
				begin
					pitch_ff     <= nxt_acc[W_PITCH_ABS-1:0];
					pitch_rel_ff <= 1'b0;
				end
				ST_PITCH_REL:
				begin
					pitch_ff     <= {{(W_PITCH_ABS-W_PITCH_REL){1'b0}}, nxt_acc[W_PITCH_REL-1:0]};
					pitch_rel_ff <= 1'b1;
				end
				ST_FILT:      filt_ff <= in_bit;
				ST_PULSE:     pulse_ff[pulse_cnt_ff] <= nxt_acc;
				ST_GAIN:      gain_ff <= nxt_acc[W_GAIN-1:0];
				ST_HBE:       hbe_ff <= nxt_acc[W_HBE-1:0];
				default:      vad_ff <= vad_ff;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign SF_VALID                 = (state_ff == ST_OUT);
	assign SF_INDEX                 = sf_ff;
	assign SF_LAST                  = (sf_ff == SUBFR_LAST);
	assign FRAME_MODE_FULL          = mode_ff;
	assign FRAME_LEN_OK             = (frame_bits_ff == exp_bits);
	assign VOICE_ACTIVITY_FLAG      = vad_ff;
	assign SF_PITCH                 = pitch_ff;
	assign SF_PITCH_RELATIVE        = pitch_rel_ff;
	assign PITCH_FILTER_SELECT_FLAG = filt_ff;
	assign SF_GAIN                  = gain_ff;
	assign SF_HB_GAIN               = mode_ff ? hbe_ff : '0;
	assign SF_HB_GAIN_VALID         = mode_ff;
	assign SPECTRAL_PAIR_SUBVECTOR  = {spv_ff[0][SPV_W0-1:0], spv_ff[1][SPV_W1-1:0],
		spv_ff[2][SPV_W2-1:0], spv_ff[3][SPV_W3-1:0], spv_ff[4][SPV_W4-1:0],
		spv_ff[5][SPV_W5-1:0], spv_ff[6][SPV_W6-1:0]};

	genvar g;
	generate
		for (g = 0; g < N_PULSE; g++)
		begin : g_pulse
			assign SF_PULSE[g*W_PULSE +: W_PULSE] = pulse_ff[g];
		end
	endgenerate

endmodule

`default_nettype wire
